//--- logic/imfb_bank.sv
// Module: interrupt mask and factor flag bank with an AXI4-Lite register slave
//
// Notes on behaviour
// - Key group 0 enable at ffe4 bit 0
// - Key groups 2/1 enables at ffe5 bits 1/0
// - Tick enables 1/2/8/16 Hz at ffe6
// - Converter done enable at ffe7 bit 0
// - Flags read cause; write one clears
// - Timer 1/0 flags at fff2 bits 1/0
// - Serial flag at fff3 bit 0
// - Key flags at fff4 and fff5
// - Tick flags 1/2/8/16 Hz at fff6
// - Unused bits read zero, writes ignored
`timescale 1ns/10ps
module imfb_bank #(
    parameter int ADDR_W = 18 // Byte address width
) (
    input wire logic clk, // System clock, 250 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire imfb_pkg::imfb_src_t src_evt, // Cause pulses, one per source
    input wire logic [2:0] ext_enable, // Outside enables: serial, timer 1, timer 0
    output logic irq // Interrupt request level
);
    // Index needs the full 16 bits above the word offset
    generate
        if (ADDR_W < imfb_pkg::IDX_W + imfb_pkg::ADDR_LSB) begin : g_chk
            $error("imfb_bank: ADDR_W too narrow for the register map");
        end
    endgenerate

    // True for every index that holds a register
    function automatic logic idx_known(input logic [15:0] idx);
        unique case (idx)
            imfb_pkg::IDX_KG0_EN, imfb_pkg::IDX_KG12_EN,
            imfb_pkg::IDX_TICK_EN, imfb_pkg::IDX_CONV_EN,
            imfb_pkg::IDX_PT_PEND, imfb_pkg::IDX_SER_PEND,
            imfb_pkg::IDX_KG0_PEND, imfb_pkg::IDX_KG12_PEND,
            imfb_pkg::IDX_TICK_PEND, imfb_pkg::IDX_CONV_PEND,
            imfb_pkg::IDX_EVT_STS, imfb_pkg::IDX_EVT_MSK: idx_known = 1'b1;
            default: idx_known = 1'b0;
        endcase
    endfunction : idx_known

    // Word index of a byte address
    function automatic logic [15:0] to_idx(input logic [ADDR_W-1:0] a);
        to_idx = a[imfb_pkg::ADDR_LSB +: imfb_pkg::IDX_W];
    endfunction : to_idx

    imfb_pkg::imfb_wr_state_t wr_state_reg, wr_state_next; // Write channel state
    imfb_pkg::imfb_rd_state_t rd_state_reg, rd_state_next; // Read channel state
    logic aw_have_reg, aw_have_next; // Write address held
    logic w_have_reg, w_have_next; // Write data held
    logic [15:0] aw_idx_reg, aw_idx_next; // Held write index
    logic [31:0] w_data_reg, w_data_next; // Held write data
    logic w_lane0_reg, w_lane0_next; // Byte lane 0 strobe held
    logic [1:0] bresp_reg, bresp_next; // Write response
    logic [31:0] rdata_reg, rdata_next; // Read data
    logic [1:0] rresp_reg, rresp_next; // Read response
    logic [15:0] rd_idx_reg, rd_idx_next; // Index of last read, for checking
    imfb_pkg::imfb_src_t en_reg, en_next; // Local enable bits
    imfb_pkg::imfb_src_t evt_msk_reg, evt_msk_next; // Event status mask
    imfb_pkg::imfb_src_t pend, pend_clr; // Factor flags and their clears
    imfb_pkg::imfb_src_t sts, sts_clr; // Event status and its clears
    imfb_pkg::imfb_src_t eff_en; // Enables as seen by the request
    logic irq_reg, irq_next; // Registered request
    logic wr_go; // Both halves of a write are held
    logic wr_ok; // Write hits a register
    logic wr_l0; // Write touches the register lane
    logic ar_fire; // Read address taken
    logic [15:0] ar_idx; // Index of the read being taken
    logic [3:0] wn; // Low nibble of the write data

    assign wr_go = (wr_state_reg == imfb_pkg::WR_COLLECT) & aw_have_reg & w_have_reg;
    assign wr_ok = idx_known(aw_idx_reg);
    assign wr_l0 = wr_go & wr_ok & w_lane0_reg;
    assign wn = w_data_reg[imfb_pkg::NIB_W-1:0];
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign ar_idx = to_idx(s_axi_araddr);

    // Each channel is ready until its half of the write is held
    assign s_axi_awready = (wr_state_reg == imfb_pkg::WR_COLLECT) & ~aw_have_reg;
    assign s_axi_wready = (wr_state_reg == imfb_pkg::WR_COLLECT) & ~w_have_reg;
    assign s_axi_bvalid = (wr_state_reg == imfb_pkg::WR_RESP);
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = (rd_state_reg == imfb_pkg::RD_IDLE);
    assign s_axi_rvalid = (rd_state_reg == imfb_pkg::RD_DATA);
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;

    // Write channel: take address and data in either order, answer once both are in
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_idx_next = aw_idx_reg;
        w_data_next = w_data_reg;
        w_lane0_next = w_lane0_reg;
        bresp_next = bresp_reg;
        unique case (wr_state_reg)
            imfb_pkg::WR_COLLECT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_next = 1'b1;
                    aw_idx_next = to_idx(s_axi_awaddr);
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_next = 1'b1;
                    w_data_next = s_axi_wdata;
                    w_lane0_next = s_axi_wstrb[0];
                end
                if (wr_go) begin
                    // Unmapped index gets an error, nothing is stored
                    bresp_next = wr_ok ? imfb_pkg::RESP_OKAY : imfb_pkg::RESP_SLVERR;
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    wr_state_next = imfb_pkg::WR_RESP;
                end
            end
            imfb_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_next = imfb_pkg::WR_COLLECT;
                end
            end
        endcase
    end

    // Write channel registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= imfb_pkg::WR_COLLECT;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_idx_reg <= '0;
            w_data_reg <= imfb_pkg::DATA_ZERO;
            w_lane0_reg <= 1'b0;
            bresp_reg <= imfb_pkg::RESP_OKAY;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_idx_reg <= aw_idx_next;
            w_data_reg <= w_data_next;
            w_lane0_reg <= w_lane0_next;
            bresp_reg <= bresp_next;
        end
    end

    // Enable registers; only documented bit positions are stored
    always_comb begin
        en_next = en_reg;
        evt_msk_next = evt_msk_reg;
        if (wr_l0) begin
            unique case (aw_idx_reg)
                imfb_pkg::IDX_KG0_EN: begin
                    en_next.key_group0 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_KG12_EN: begin
                    en_next.key_group2 = wn[imfb_pkg::BIT_D1];
                    en_next.key_group1 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_TICK_EN: begin
                    en_next.tick1 = wn[imfb_pkg::BIT_D3];
                    en_next.tick2 = wn[imfb_pkg::BIT_D2];
                    en_next.tick8 = wn[imfb_pkg::BIT_D1];
                    en_next.tick16 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_CONV_EN: begin
                    en_next.converter_done = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_EVT_MSK: begin
                    evt_msk_next = w_data_reg[imfb_pkg::SRC_W-1:0];
                end
                default: begin
                    // Flag registers are handled by the clear logic
                end
            endcase
        end
    end

    // Enable registers, cleared at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= imfb_pkg::SRC_RESET;
            evt_msk_reg <= imfb_pkg::SRC_RESET;
        end else begin
            en_reg <= en_next;
            evt_msk_reg <= evt_msk_next;
        end
    end

    // Write-one-to-clear decode; a zero leaves the flag alone
    always_comb begin
        pend_clr = imfb_pkg::SRC_RESET;
        if (wr_l0) begin
            unique case (aw_idx_reg)
                imfb_pkg::IDX_PT_PEND: begin
                    pend_clr.prog_timer1 = wn[imfb_pkg::BIT_D1];
                    pend_clr.prog_timer0 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_SER_PEND: begin
                    pend_clr.serial = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_KG0_PEND: begin
                    pend_clr.key_group0 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_KG12_PEND: begin
                    pend_clr.key_group2 = wn[imfb_pkg::BIT_D1];
                    pend_clr.key_group1 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_TICK_PEND: begin
                    pend_clr.tick1 = wn[imfb_pkg::BIT_D3];
                    pend_clr.tick2 = wn[imfb_pkg::BIT_D2];
                    pend_clr.tick8 = wn[imfb_pkg::BIT_D1];
                    pend_clr.tick16 = wn[imfb_pkg::BIT_D0];
                end
                imfb_pkg::IDX_CONV_PEND: begin
                    pend_clr.converter_done = wn[imfb_pkg::BIT_D0];
                end
                default: begin
                    // Enable registers have nothing to clear
                end
            endcase
        end
    end

    // Factor flags; an event in the clearing cycle keeps its flag
    imfb_sticky #(.W(imfb_pkg::SRC_W)) u_pend (
        .clk(clk),
        .rst_n(rst_n),
        .set(src_evt),
        .clr(pend_clr),
        .q(pend)
    );

    // Event status is cleared whole by a read of its register
    assign sts_clr = (ar_fire && ar_idx == imfb_pkg::IDX_EVT_STS) ? '1 : imfb_pkg::SRC_RESET;

    // Sticky event record, same layout as the flags
    imfb_sticky #(.W(imfb_pkg::SRC_W)) u_sts (
        .clk(clk),
        .rst_n(rst_n),
        .set(src_evt),
        .clr(sts_clr),
        .q(sts)
    );

    // Read channel: data is registered, so the answer comes one cycle after ar
    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        rd_idx_next = rd_idx_reg;
        unique case (rd_state_reg)
            imfb_pkg::RD_IDLE: begin
                if (ar_fire) begin
                    rd_idx_next = ar_idx;
                    rdata_next = imfb_pkg::DATA_ZERO;
                    rresp_next = idx_known(ar_idx) ? imfb_pkg::RESP_OKAY
                                                   : imfb_pkg::RESP_SLVERR;
                    unique case (ar_idx)
                        imfb_pkg::IDX_KG0_EN: rdata_next[0] = en_reg.key_group0;
                        imfb_pkg::IDX_KG12_EN:
                            rdata_next[1:0] = {en_reg.key_group2, en_reg.key_group1};
                        imfb_pkg::IDX_TICK_EN: rdata_next[3:0] = {en_reg.tick1,
                            en_reg.tick2, en_reg.tick8, en_reg.tick16};
                        imfb_pkg::IDX_CONV_EN: rdata_next[0] = en_reg.converter_done;
                        imfb_pkg::IDX_PT_PEND:
                            rdata_next[1:0] = {pend.prog_timer1, pend.prog_timer0};
                        imfb_pkg::IDX_SER_PEND: rdata_next[0] = pend.serial;
                        imfb_pkg::IDX_KG0_PEND: rdata_next[0] = pend.key_group0;
                        imfb_pkg::IDX_KG12_PEND:
                            rdata_next[1:0] = {pend.key_group2, pend.key_group1};
                        imfb_pkg::IDX_TICK_PEND: rdata_next[3:0] = {pend.tick1,
                            pend.tick2, pend.tick8, pend.tick16};
                        imfb_pkg::IDX_CONV_PEND: rdata_next[0] = pend.converter_done;
                        imfb_pkg::IDX_EVT_STS: rdata_next[10:0] = sts;
                        imfb_pkg::IDX_EVT_MSK: rdata_next[10:0] = evt_msk_reg;
                        default: rdata_next = imfb_pkg::DATA_ZERO;
                    endcase
                    rd_state_next = imfb_pkg::RD_DATA;
                end
            end
            imfb_pkg::RD_DATA: begin
                if (s_axi_rready) begin
                    rd_state_next = imfb_pkg::RD_IDLE;
                end
            end
        endcase
    end

    // Read channel registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_reg <= imfb_pkg::RD_IDLE;
            rdata_reg <= imfb_pkg::DATA_ZERO;
            rresp_reg <= imfb_pkg::RESP_OKAY;
            rd_idx_reg <= '0;
        end else begin
            rd_state_reg <= rd_state_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            rd_idx_reg <= rd_idx_next;
        end
    end

    // Timer and serial enables live elsewhere and arrive as levels
    always_comb begin
        eff_en = en_reg;
        eff_en.serial = ext_enable[2];
        eff_en.prog_timer1 = ext_enable[1];
        eff_en.prog_timer0 = ext_enable[0];
    end

    // Request level; registered so the pin never glitches on decode
    always_comb begin
        irq_next = (|(pend & eff_en)) | (|(sts & evt_msk_reg));
    end

    // Request register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Checks on the bank
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_w1c_conv;
        wr_l0 && aw_idx_reg == imfb_pkg::IDX_CONV_PEND && wn[0] && !src_evt.converter_done;
    endsequence

    kg0_en_wr_a: assert property (wr_l0 && aw_idx_reg == imfb_pkg::IDX_KG0_EN
        |=> en_reg.key_group0 == $past(w_data_reg[0])) else $error("key 0 enable");
    kg12_en_wr_a: assert property (wr_l0 && aw_idx_reg == imfb_pkg::IDX_KG12_EN
        |=> {en_reg.key_group2, en_reg.key_group1} == $past(w_data_reg[1:0]))
        else $error("key 1/2 enable");
    tick_en_wr_a: assert property (wr_l0 && aw_idx_reg == imfb_pkg::IDX_TICK_EN
        |=> {en_reg.tick1, en_reg.tick2, en_reg.tick8, en_reg.tick16}
        == $past(w_data_reg[3:0])) else $error("tick enable");
    conv_en_keep_a: assert property (!(wr_l0 && aw_idx_reg == imfb_pkg::IDX_CONV_EN)
        |=> $stable(en_reg.converter_done)) else $error("converter enable moved");
    conv_w1c_a: assert property (s_w1c_conv ##1 !src_evt.converter_done
        |-> !pend.converter_done) else $error("converter flag not cleared");
    pt_set_a: assert property (src_evt.prog_timer1 |=> pend.prog_timer1 [*1])
        else $error("timer 1 flag not set");
    ser_hold_a: assert property (pend.serial && !pend_clr.serial |=> pend.serial)
        else $error("serial flag dropped");
    key_set_wins_a: assert property (src_evt.key_group1 && pend_clr.key_group1
        |=> pend.key_group1) else $error("key 1 event lost");
    tick_rd_a: assert property (ar_fire && ar_idx == imfb_pkg::IDX_TICK_PEND
        |=> s_axi_rdata[3:0] == $past({pend.tick1, pend.tick2, pend.tick8, pend.tick16}))
        else $error("tick flag readback");
    unused_zero_a: assert property (s_axi_rvalid && rd_idx_reg != imfb_pkg::IDX_EVT_STS
        && rd_idx_reg != imfb_pkg::IDX_EVT_MSK |-> s_axi_rdata[31:4] == '0)
        else $error("unused bits not zero");
    irq_level_a: assert property ((|(pend & eff_en)) |=> irq)
        else $error("request missing");
endmodule : imfb_bank

//--- shared/imfb_pkg.sv
// Package: register map, field layout and types of the interrupt mask and flag bank
package imfb_pkg;
    // Register indices; byte address is index times four
    localparam int IDX_W = 16;
    localparam int ADDR_LSB = 2;
    localparam logic [15:0] IDX_KG0_EN = 16'hffe4;
    localparam logic [15:0] IDX_KG12_EN = 16'hffe5;
    localparam logic [15:0] IDX_TICK_EN = 16'hffe6;
    localparam logic [15:0] IDX_CONV_EN = 16'hffe7;
    localparam logic [15:0] IDX_PT_PEND = 16'hfff2;
    localparam logic [15:0] IDX_SER_PEND = 16'hfff3;
    localparam logic [15:0] IDX_KG0_PEND = 16'hfff4;
    localparam logic [15:0] IDX_KG12_PEND = 16'hfff5;
    localparam logic [15:0] IDX_TICK_PEND = 16'hfff6;
    localparam logic [15:0] IDX_CONV_PEND = 16'hfff7;
    localparam logic [15:0] IDX_EVT_STS = 16'hfff8;
    localparam logic [15:0] IDX_EVT_MSK = 16'hfff9;
    // Bit positions inside a 4-bit register
    localparam int BIT_D0 = 0;
    localparam int BIT_D1 = 1;
    localparam int BIT_D2 = 2;
    localparam int BIT_D3 = 3;
    localparam int NIB_W = 4;
    localparam int SRC_W = 11;
    // Reset values
    localparam logic [10:0] SRC_RESET = 11'h000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // One bit per interrupt source
    typedef struct packed {
        logic converter_done;
        logic tick1;
        logic tick2;
        logic tick8;
        logic tick16;
        logic key_group2;
        logic key_group1;
        logic key_group0;
        logic serial;
        logic prog_timer1;
        logic prog_timer0;
    } imfb_src_t;
    // Write channel state
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } imfb_wr_state_t;
    // Read channel state
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } imfb_rd_state_t;
endpackage : imfb_pkg

//--- logic/imfb_sticky.sv
// Module: bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/10ps
module imfb_sticky #(
    parameter int W = 11 // Number of flags
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] set, // Set pulses, one per flag
    input wire logic [W-1:0] clr, // Clear pulses, one per flag
    output logic [W-1:0] q // Flag state
);
    logic [W-1:0] q_reg; // Stored flags
    logic [W-1:0] q_next; // Next flag state

    generate
        if (W < 1) begin : g_chk
            $error("imfb_sticky: W must be at least 1");
        end
    endgenerate

    // Clear first, then set, so an event in the clear cycle survives
    always_comb begin
        q_next = (q_reg & ~clr) | set;
    end

    // Flags register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule : imfb_sticky

//--- testbench/imfb_cpu_model.sv
// CPU interrupt input model that samples the request level
`timescale 1ns/10ps
module imfb_cpu_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic irq, // Request level from the bank
    output logic irq_seen // Level as the core latched it
);
    // The core samples the request once a clock; a short glitch is lost, as on silicon
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen <= 1'b0; // No request after reset
        end else begin
            irq_seen <= irq; // Follows the level while a flag meets its enable or a record bit meets its mask
        end
    end
endmodule : imfb_cpu_model

//--- testbench/tb_imfb_bank.sv
// Self-checking bench for the interrupt mask and flag bank
`timescale 1ns/10ps
module tb_imfb_bank;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, irq_seen;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0; // Byte addresses
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] ext_enable = 3'h0; // Serial and timer enables from outside
    imfb_pkg::imfb_src_t src_evt = '0; // Cause pulses
    logic [33:0] exp_q[$]; // Expected {rresp, rdata}, oldest first
    logic [15:0] r = 16'h0001; // Random state
    int err_count = 0, tests_run = 0;
    logic [15:0] en_idx[4] = '{16'hffe4, 16'hffe5, 16'hffe6, 16'hffe7};
    logic [3:0] en_msk[4] = '{4'h1, 4'h3, 4'hf, 4'h1}; // Implemented enable bits
    logic [15:0] pd_idx[6] = '{16'hfff2, 16'hfff3, 16'hfff4, 16'hfff5, 16'hfff6, 16'hfff7};
    logic [3:0] pd_msk[6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hf, 4'h1}; // Implemented flag bits
    // Clock at 250 MHz
    always #2 clk = ~clk;
    imfb_bank uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .src_evt(src_evt), .ext_enable(ext_enable), .irq(irq));
    imfb_cpu_model cpu (.clk(clk), .rst_n(rst_n), .irq(irq), .irq_seen(irq_seen));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk
    // Write one word; address and data are released each at its own ready
    task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic a, w;
        n = 0;
        a = 1'b1;
        w = 1'b1;
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while ((a | w) && n < 50) begin
            @(posedge clk);
            n++;
            if (a && awready) begin a = 1'b0; awvalid <= 1'b0; end
            if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
        end
        do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) err_count++; // A write that never answers is a failure
        chk({32'h0, bresp}, {32'h0, er});
    endtask : wr
    // Read one word; the monitor compares the answer against the note
    task automatic rd(input logic [15:0] i, input logic [1:0] er, input logic [31:0] d);
        int n;
        n = 0;
        exp_q.push_back({er, d});
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) err_count++; // A read that never answers is a failure
    endtask : rd
    task automatic pulse(input logic [10:0] s);
        src_evt <= imfb_pkg::imfb_src_t'(s);
        @(posedge clk);
        src_evt <= '0;
        @(posedge clk);
    endtask : pulse
    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk); // Registered request plus the core's sample
        chk({33'h0, irq_seen}, {33'h0, v});
    endtask : irq_is
    // Monitor: each read answer takes the oldest note
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk(34'h0, 34'h1);
            else chk({rresp, rdata}, exp_q.pop_front());
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #80000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (en_idx[i]) rd(en_idx[i], imfb_pkg::RESP_OKAY, 32'h0);
        foreach (pd_idx[i]) rd(pd_idx[i], imfb_pkg::RESP_OKAY, 32'h0);
        $display("test reset values done");
        foreach (en_idx[i]) begin
            wr(en_idx[i], 32'hffff_ffff, imfb_pkg::RESP_OKAY);
            rd(en_idx[i], imfb_pkg::RESP_OKAY, {28'h0, en_msk[i]});
        end
        repeat (4) begin
            r = lfsr(r);
            wr(16'hffe6, {16'h0, r}, imfb_pkg::RESP_OKAY);
            rd(16'hffe6, imfb_pkg::RESP_OKAY, {28'h0, r[3:0]});
        end
        wr(16'hffe6, 32'hf, imfb_pkg::RESP_OKAY);
        $display("test enables done");
        ext_enable <= 3'h7;
        pulse(11'h7ff);
        foreach (pd_idx[i]) rd(pd_idx[i], imfb_pkg::RESP_OKAY, {28'h0, pd_msk[i]});
        irq_is(1'b1);
        foreach (pd_idx[i]) begin
            wr(pd_idx[i], 32'hffff_fff0, imfb_pkg::RESP_OKAY);
            rd(pd_idx[i], imfb_pkg::RESP_OKAY, {28'h0, pd_msk[i]});
            wr(pd_idx[i], 32'hf, imfb_pkg::RESP_OKAY);
            rd(pd_idx[i], imfb_pkg::RESP_OKAY, 32'h0);
        end
        irq_is(1'b0);
        $display("test flags done");
        wr(16'hffe7, 32'h0, imfb_pkg::RESP_OKAY);
        pulse(11'h400);
        irq_is(1'b0);
        wr(16'hffe7, 32'h1, imfb_pkg::RESP_OKAY);
        irq_is(1'b1);
        wr(16'hfff7, 32'h1, imfb_pkg::RESP_OKAY);
        irq_is(1'b0);
        $display("test request done");
        // Event record: read returns every event so far, then comes back empty
        rd(16'hfff8, imfb_pkg::RESP_OKAY, 32'h0000_07ff);
        rd(16'hfff8, imfb_pkg::RESP_OKAY, 32'h0);
        wr(16'hfff9, 32'h4, imfb_pkg::RESP_OKAY);
        rd(16'hfff9, imfb_pkg::RESP_OKAY, 32'h4);
        // Outside enables off, so the serial flag cannot raise the request; only the unmasked serial bit of the record raises it
        ext_enable <= 3'h0;
        pulse(11'h004);
        irq_is(1'b1);
        rd(16'hfff8, imfb_pkg::RESP_OKAY, 32'h4);
        irq_is(1'b0);
        $display("test event record done");
        rd(16'h0000, imfb_pkg::RESP_SLVERR, 32'h0);
        wr(16'h0000, 32'hf, imfb_pkg::RESP_SLVERR);
        $display("test unmapped done");
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule : tb_imfb_bank
